// file: hw/pmwc_consts.svh
// Purpose: offsets, field positions, reset values, timing counts
// Assumes: 32-bit classic Wishbone, byte address = 4 * index
// Notes: definitions only
`ifndef PMWC_CONSTS_SVH
`define PMWC_CONSTS_SVH

// Register indices, byte address is four times the index
`define PMWC_IDX_PWR_CTRL 8'h87
`define PMWC_IDX_CLK_SEL 8'h8F
`define PMWC_IDX_WAKE_MASK 8'h9F
`define PMWC_IDX_TLOCK 8'hC0
`define PMWC_IDX_STAT 8'hC1

// Power control fields
`define PMWC_PWR_IDLE 0
`define PMWC_PWR_STOP 1
`define PMWC_PWR_SLEEP 2

// Clock select fields
`define PMWC_CK_SRC_LO 0
`define PMWC_CK_SET_LO 2

// Reset values
`define PMWC_WAKE_MASK_RST 8'hFF
`define PMWC_SRC_RST 2'h0
`define PMWC_SET_RST 2'h3

// Clock source codes
`define PMWC_SRC_SLOW 2'h1
`define PMWC_SRC_EXT 2'h3

// Unlock sequence and window
`define PMWC_KEY1 8'hAA
`define PMWC_KEY2 8'h55
`define PMWC_UNLOCK_CYC 4

// Slow oscillator and settle delays
`define PMWC_CLK_HZ 10000000
`define PMWC_SLOW_HZ 32768
`define PMWC_SLOW_DIV (`PMWC_CLK_HZ / `PMWC_SLOW_HZ)
`define PMWC_SET0 9'd8
`define PMWC_SET1 9'd16
`define PMWC_SET2 9'd64
`define PMWC_SET3 9'd256

`endif

// file: hw/pmwc_ctrl.sv
// Purpose: power mode and wake-up controller with Wishbone registers
// Assumes: clk_i always on, also standing in for the clockless wake path
// Notes: 8-bit registers in the low byte of a 32-bit bus word
`timescale 1ns/100ps
`include "pmwc_consts.svh"

module pmwc_ctrl #(
  parameter int SLOW_DIV = `PMWC_SLOW_DIV,
  parameter int UNLOCK_CYC = `PMWC_UNLOCK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] wake_line_i,
  input wire logic [2:0] clockless_wake_i,
  input wire logic idle_exit_irq_i,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic fast_osc_en_o,
  output logic main_reg_en_o,
  output logic [1:0] clk_src_o,
  output logic wdt_clk_en_o,
  output logic wake_o,
  output logic [1:0] wake_mode_o
);

  // Elaboration checks on parameters the logic cannot serve
  initial begin
    if (SLOW_DIV < 2 || SLOW_DIV > 65535) begin
      $error("pmwc_ctrl: SLOW_DIV out of range");
    end
    if (UNLOCK_CYC < 1 || UNLOCK_CYC > 255) begin
      $error("pmwc_ctrl: UNLOCK_CYC out of range");
    end
  end

  localparam logic [15:0] DIV_LAST = 16'(SLOW_DIV - 1);
  localparam logic [7:0] UNL_LOAD = 8'(UNLOCK_CYC);

  pmwc_pkg::pmwc_state_t state_reg;
  pmwc_pkg::pmwc_state_t state_next;
  logic [7:0] wake_source_mask_reg;
  logic [1:0] src_reg;
  logic [1:0] settle_sel_reg;
  logic [2:0] power_control_reg;
  logic [7:0] unlock_cnt_reg;
  logic key1_seen_reg;
  logic [15:0] div_cnt_reg;
  logic slow_tick_reg;
  logic [8:0] settle_cnt_reg;
  logic [8:0] settle_len;
  logic [7:0] line_prev_reg;
  logic [2:0] cl_prev_reg;
  logic wake_hold_reg;
  logic edge_now;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic unlocked;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rdata;
  logic pwr_ctrl_wr;
  logic exit_idle;
  logic exit_halt;
  logic settle_done;

  // Bus decode, one request answered per ack
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_rd = bus_req && !wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];
  assign unlocked = unlock_cnt_reg != 8'h00;
  assign pwr_ctrl_wr = bus_wr && (wb_adr_i[11:10] == 2'b00) &&
                       (idx == `PMWC_IDX_PWR_CTRL);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Timed unlock: two keys back to back open a short window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key1_seen_reg <= 1'b0;
      unlock_cnt_reg <= 8'h00;
    end else if (bus_wr && idx == `PMWC_IDX_TLOCK &&
                 wb_adr_i[11:10] == 2'b00) begin
      key1_seen_reg <= (wbyte == `PMWC_KEY1);
      if (key1_seen_reg && wbyte == `PMWC_KEY2) begin
        unlock_cnt_reg <= UNL_LOAD;
      end else begin
        unlock_cnt_reg <= 8'h00;
      end
    end else if (bus_wr && unlocked) begin
      unlock_cnt_reg <= 8'h00; // One protected write per unlock
    end else if (unlocked) begin
      unlock_cnt_reg <= unlock_cnt_reg - 8'h01;
    end
  end

  // Wake mask, protected by the unlock window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_source_mask_reg <= `PMWC_WAKE_MASK_RST;
    end else if (bus_wr && unlocked && wb_adr_i[11:10] == 2'b00 &&
                 idx == `PMWC_IDX_WAKE_MASK) begin
      wake_source_mask_reg <= wbyte;
    end
  end

  // Clock select: source and settle fields, also protected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_reg <= `PMWC_SRC_RST;
      settle_sel_reg <= `PMWC_SET_RST;
    end else if (bus_wr && unlocked && wb_adr_i[11:10] == 2'b00 &&
                 idx == `PMWC_IDX_CLK_SEL) begin
      src_reg <= wbyte[`PMWC_CK_SRC_LO +: 2];
      settle_sel_reg <= wbyte[`PMWC_CK_SET_LO +: 2];
    end
  end

  // Read mux; settle field is write-only and reads zero
  always_comb begin
    rdata = 8'h00;
    if (wb_adr_i[11:10] != 2'b00) begin
      rdata = 8'h00;
    end else if (idx == `PMWC_IDX_WAKE_MASK) begin
      rdata = wake_source_mask_reg;
    end else if (idx == `PMWC_IDX_CLK_SEL) begin
      rdata = {6'h00, src_reg};
    end else if (idx == `PMWC_IDX_PWR_CTRL) begin
      rdata = {5'h00, power_control_reg};
    end else if (idx == `PMWC_IDX_STAT) begin
      rdata = {unlocked, wake_hold_reg, 3'h0, state_reg};
    end
  end

  // Read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      wb_dat_o <= {24'h00_0000, rdata};
    end
  end

  // Slow oscillator tick from the always-on clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_reg <= 16'h0000;
      slow_tick_reg <= 1'b0;
    end else if (div_cnt_reg == DIV_LAST) begin
      div_cnt_reg <= 16'h0000;
      slow_tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
      slow_tick_reg <= 1'b0;
    end
  end

  // Edge detect on masked pins and clockless sources only
  assign edge_now = |(wake_line_i & ~line_prev_reg &
                      wake_source_mask_reg) ||
                    |(clockless_wake_i & ~cl_prev_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_prev_reg <= 8'h00;
      cl_prev_reg <= 3'h0;
    end else begin
      line_prev_reg <= wake_line_i;
      cl_prev_reg <= clockless_wake_i;
    end
  end

  // Hold a wake edge until the halted state consumes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_hold_reg <= 1'b0;
    end else if (edge_now && (state_reg == pmwc_pkg::PM_STOP ||
                 state_reg == pmwc_pkg::PM_SLEEP)) begin
      wake_hold_reg <= 1'b1;
    end else if (state_reg != pmwc_pkg::PM_STOP &&
                 state_reg != pmwc_pkg::PM_SLEEP) begin
      wake_hold_reg <= 1'b0;
    end
  end

  // Wake does not look at interrupt enables at all
  assign exit_halt = wake_hold_reg;
  assign exit_idle = idle_exit_irq_i;

  // Settle length in slow cycles
  always_comb begin
    case (settle_sel_reg)
      2'd0: settle_len = `PMWC_SET0;
      2'd1: settle_len = `PMWC_SET1;
      2'd2: settle_len = `PMWC_SET2;
      default: settle_len = `PMWC_SET3;
    endcase
  end

  assign settle_done = slow_tick_reg && (settle_cnt_reg == 9'd1);

  // Settle counter runs on slow ticks only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_cnt_reg <= 9'd0;
    end else if (state_reg == pmwc_pkg::PM_SLEEP && exit_halt) begin
      settle_cnt_reg <= settle_len;
    end else if (state_reg == pmwc_pkg::PM_SETTLE && slow_tick_reg &&
                 settle_cnt_reg != 9'd0) begin
      settle_cnt_reg <= settle_cnt_reg - 9'd1;
    end
  end

  // Mode sequencer; highest mode bit written wins
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pmwc_pkg::PM_NORMAL: begin
        if (pwr_ctrl_wr && wbyte[`PMWC_PWR_SLEEP]) begin
          state_next = pmwc_pkg::PM_SLEEP;
        end else if (pwr_ctrl_wr && wbyte[`PMWC_PWR_STOP]) begin
          state_next = pmwc_pkg::PM_STOP;
        end else if (pwr_ctrl_wr && wbyte[`PMWC_PWR_IDLE]) begin
          state_next = pmwc_pkg::PM_IDLE;
        end
      end
      pmwc_pkg::PM_IDLE: begin
        if (exit_idle) begin
          state_next = pmwc_pkg::PM_NORMAL;
        end
      end
      pmwc_pkg::PM_STOP: begin
        if (exit_halt) begin
          state_next = pmwc_pkg::PM_NORMAL;
        end
      end
      pmwc_pkg::PM_SLEEP: begin
        if (exit_halt) begin
          state_next = pmwc_pkg::PM_SETTLE;
        end
      end
      pmwc_pkg::PM_SETTLE: begin
        if (settle_done) begin
          state_next = pmwc_pkg::PM_NORMAL;
        end
      end
      default: state_next = pmwc_pkg::PM_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= pmwc_pkg::PM_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // Mode bits follow the sequencer; hardware clears them on exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_control_reg <= 3'h0;
    end else begin
      power_control_reg[`PMWC_PWR_IDLE] <=
        state_next == pmwc_pkg::PM_IDLE;
      power_control_reg[`PMWC_PWR_STOP] <=
        state_next == pmwc_pkg::PM_STOP;
      power_control_reg[`PMWC_PWR_SLEEP] <= state_next == pmwc_pkg::PM_SLEEP ||
                                            state_next == pmwc_pkg::PM_SETTLE;
    end
  end

  // Clock and regulator gates from the next state, so the oscillator
  // drops on the same edge that enters stop and no pulse is cut short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o <= 1'b1;
      periph_clk_en_o <= 1'b1;
      fast_osc_en_o <= 1'b1;
      main_reg_en_o <= 1'b1;
      wdt_clk_en_o <= 1'b1;
    end else begin
      cpu_clk_en_o <= state_next == pmwc_pkg::PM_NORMAL;
      wdt_clk_en_o <= state_next == pmwc_pkg::PM_NORMAL;
      periph_clk_en_o <= state_next == pmwc_pkg::PM_NORMAL ||
                         state_next == pmwc_pkg::PM_IDLE;
      fast_osc_en_o <= state_next == pmwc_pkg::PM_NORMAL ||
                       state_next == pmwc_pkg::PM_IDLE;
      main_reg_en_o <= state_next != pmwc_pkg::PM_SLEEP;
    end
  end

  // Source select held through halts, so exit restores it unchanged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_src_o <= `PMWC_SRC_RST;
    end else if (src_reg == `PMWC_SRC_SLOW ||
                 src_reg == `PMWC_SRC_EXT) begin
      clk_src_o <= src_reg;
    end else begin
      clk_src_o <= `PMWC_SRC_RST;
    end
  end

  // Wake pulse names the ended mode; the core picks its return point
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
      wake_mode_o <= pmwc_pkg::WK_NONE;
    end else if (state_reg == pmwc_pkg::PM_IDLE && exit_idle) begin
      wake_o <= 1'b1;
      wake_mode_o <= pmwc_pkg::WK_IDLE;
    end else if (state_reg == pmwc_pkg::PM_STOP && exit_halt) begin
      wake_o <= 1'b1;
      wake_mode_o <= pmwc_pkg::WK_STOP;
    end else if (state_reg == pmwc_pkg::PM_SETTLE && settle_done) begin
      wake_o <= 1'b1;
      wake_mode_o <= pmwc_pkg::WK_SLEEP;
    end else begin
      wake_o <= 1'b0;
    end
  end

endmodule : pmwc_ctrl

// file: hw/pmwc_pkg.sv
// Purpose: types shared by the power mode controller
// Assumes: nothing beyond the constants header
// Notes: types only
package pmwc_pkg;

  typedef enum logic [2:0] {
    PM_NORMAL,
    PM_IDLE,
    PM_STOP,
    PM_SLEEP,
    PM_SETTLE
  } pmwc_state_t;

  typedef enum logic [1:0] {
    WK_NONE,
    WK_IDLE,
    WK_STOP,
    WK_SLEEP
  } pmwc_wake_t;

endpackage : pmwc_pkg

// file: verification/pmwc_ctrl_props.sv
// Purpose: port-level checks of the power mode controller
// Assumes: single clock domain, rst_i synchronous active high
// Notes: mode is inferred from the gate outputs, no internal probes
`timescale 1ns/100ps
module pmwc_ctrl_chk #(
  parameter int SLOW_DIV = 305,
  parameter int UNLOCK_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] wake_line_i,
  input wire logic [2:0] clockless_wake_i,
  input wire logic idle_exit_irq_i,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic fast_osc_en_o,
  input wire logic main_reg_en_o,
  input wire logic [1:0] clk_src_o,
  input wire logic wdt_clk_en_o,
  input wire logic wake_o,
  input wire logic [1:0] wake_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Reset check cannot be disabled by the reset it watches
  chk_reset_values: assert property (disable iff (1'b0) rst_i |=>
    cpu_clk_en_o && main_reg_en_o && clk_src_o == 2'h0 && !wake_o)
    else $error("outputs not at reset values");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack missing or long");
  chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_src_code: assert property (clk_src_o != 2'h2)
    else $error("illegal clock source code");
  chk_wdt_gate: assert property (wdt_clk_en_o == cpu_clk_en_o)
    else $error("watchdog gate differs from cpu gate");
  chk_osc_gates_all: assert property (!fast_osc_en_o |->
    !cpu_clk_en_o && !periph_clk_en_o) else $error("clock runs without osc");
  chk_sleep_halts: assert property (!main_reg_en_o |->
    !fast_osc_en_o && !cpu_clk_en_o) else $error("clock runs in sleep");
  chk_wake_restore: assert property (wake_o |-> cpu_clk_en_o &&
    periph_clk_en_o && fast_osc_en_o && main_reg_en_o)
    else $error("wake without restored clocks");
  chk_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");
  chk_idle_exit: assert property (!cpu_clk_en_o && periph_clk_en_o &&
    idle_exit_irq_i |=> wake_o && wake_mode_o == 2'h1 && cpu_clk_en_o)
    else $error("idle not left on interrupt");
  chk_cpu_restart: assert property ($rose(cpu_clk_en_o) |-> fast_osc_en_o)
    else $error("cpu clock restarted without osc");

  // Main scenarios reached
  cov_idle_wake: cover property (wake_o && wake_mode_o == 2'h1);
  cov_stop_wake: cover property (wake_o && wake_mode_o == 2'h2);
  cov_sleep_wake: cover property (wake_o && wake_mode_o == 2'h3);
  cov_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule : pmwc_ctrl_chk

bind pmwc_ctrl pmwc_ctrl_chk #(.SLOW_DIV(SLOW_DIV), .UNLOCK_CYC(UNLOCK_CYC))
  i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wake_line_i(wake_line_i),
  .clockless_wake_i(clockless_wake_i), .idle_exit_irq_i(idle_exit_irq_i),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .fast_osc_en_o(fast_osc_en_o), .main_reg_en_o(main_reg_en_o),
  .clk_src_o(clk_src_o), .wdt_clk_en_o(wdt_clk_en_o), .wake_o(wake_o),
  .wake_mode_o(wake_mode_o));

// file: verification/pmwc_far_model.sv
// Purpose: far side: wake pins, clockless sources, interrupt logic
// Assumes: changes land by non-blocking assignment on rising clk_i
// Notes: lines idle low; irq is dropped once the core clock runs
`timescale 1ns/100ps
module pmwc_far_model (
  input wire logic clk_i,
  input wire logic cpu_clk_en_i,
  output logic [7:0] wake_line_o,
  output logic [2:0] clockless_o,
  output logic irq_o
);
  // Quiet lines at time zero
  initial begin
    wake_line_o = 8'h00;
    clockless_o = 3'h0;
    irq_o = 1'b0;
  end

  // One pin level change per call
  task automatic set_line(input int i, input logic v);
    @(posedge clk_i);
    wake_line_o[i] <= v;
  endtask : set_line

  // One-cycle request from a clockless source
  task automatic pulse_src(input int j);
    @(posedge clk_i);
    clockless_o[j] <= 1'b1;
    @(posedge clk_i);
    clockless_o[j] <= 1'b0;
  endtask : pulse_src

  // Held until the core clock returns, as a pending vector would be
  task automatic raise_irq();
    int n;
    n = 0;
    @(posedge clk_i);
    irq_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (cpu_clk_en_i !== 1'b1 && n < 20);
    irq_o <= 1'b0;
  endtask : raise_irq
endmodule : pmwc_far_model

// file: verification/power_mode_wakeup_control_test.sv
// Purpose: directed bench for the power mode controller
// Assumes: slow tick shortened to 4 clocks to keep sleep runs short
// Notes: bus master waits on ack, every wait is bounded
`timescale 1ns/100ps
`include "pmwc_consts.svh"
module power_mode_wakeup_control_test;
  localparam int SLOW = 4;
  localparam int SET_LEN [4] = '{8, 16, 64, 256};
  localparam int ORD [4] = '{3, 0, 1, 2};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, irq, cpu_en, per_en, osc_en, reg_en, wdt_en, wake_o, hit;
  logic [7:0] lines;
  logic [2:0] cl;
  logic [1:0] src, mode;
  int fail_count = 0, n_tests = 0, n;

  // 100 ns period
  always #50 clk_i = ~clk_i;

  pmwc_ctrl #(.SLOW_DIV(SLOW), .UNLOCK_CYC(`PMWC_UNLOCK_CYC)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wake_line_i(lines), .clockless_wake_i(cl), .idle_exit_irq_i(irq),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .fast_osc_en_o(osc_en),
    .main_reg_en_o(reg_en), .clk_src_o(src), .wdt_clk_en_o(wdt_en),
    .wake_o(wake_o), .wake_mode_o(mode));

  pmwc_far_model i_far (.clk_i(clk_i), .cpu_clk_en_i(cpu_en),
    .wake_line_o(lines), .clockless_o(cl), .irq_o(irq));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Classic cycle: hold request until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] idx,
      input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k >= 20) begin
      fail_count++;
      end_sim();
    end
  endtask : xfer

  task automatic unlock();
    xfer(1'b1, `PMWC_IDX_TLOCK, `PMWC_KEY1);
    xfer(1'b1, `PMWC_IDX_TLOCK, `PMWC_KEY2);
  endtask : unlock

  // Bounded wait for the wake pulse; caller judges hit
  task automatic wait_wake(input int lim);
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge clk_i);
      n++;
      hit = (wake_o === 1'b1);
    end
  endtask : wait_wake

  task automatic t_reset();
    xfer(1'b0, `PMWC_IDX_WAKE_MASK, 8'h00);
    check("mask reset", q, {24'h00_0000, `PMWC_WAKE_MASK_RST});
    check("source reset", src, 32'h0000_0000);
    xfer(1'b1, `PMWC_IDX_WAKE_MASK, 8'h00);
    xfer(1'b0, `PMWC_IDX_WAKE_MASK, 8'h00);
    check("locked mask write", q, 32'h0000_00FF);
    xfer(1'b0, 8'h01, 8'h00);
    check("unmapped read", q, 32'h0000_0000);
  endtask : t_reset

  // Each mask bit wakes its own line only
  task automatic t_stop_lines();
    for (int i = 0; i < 8; i++) begin
      unlock();
      xfer(1'b1, `PMWC_IDX_WAKE_MASK, 8'h01 << i);
      xfer(1'b0, `PMWC_IDX_WAKE_MASK, 8'h00);
      check("mask write", q, 32'h0000_0001 << i);
      xfer(1'b1, `PMWC_IDX_PWR_CTRL, 8'h02);
      check("stop gates", {cpu_en, per_en, osc_en}, 32'h0000_0000);
      i_far.set_line((i + 1) % 8, 1'b1);
      i_far.set_line((i + 1) % 8, 1'b0);
      wait_wake(10);
      check("masked line", hit, 32'h0000_0000);
      i_far.set_line(i, 1'b1);
      i_far.set_line(i, 1'b0);
      wait_wake(10);
      check("wake line", hit, 32'h0000_0001);
      check("stop mode", mode, 32'h0000_0002);
      xfer(1'b0, `PMWC_IDX_PWR_CTRL, 8'h00);
      check("stop bit cleared", q, 32'h0000_0000);
    end
    // A level held from before entry is no edge
    i_far.set_line(7, 1'b1);
    xfer(1'b1, `PMWC_IDX_PWR_CTRL, 8'h02);
    wait_wake(10);
    check("level no wake", hit, 32'h0000_0000);
    i_far.set_line(7, 1'b0);
    i_far.set_line(7, 1'b1);
    wait_wake(10);
    check("edge wake", hit, 32'h0000_0001);
    i_far.set_line(7, 1'b0);
  endtask : t_stop_lines

  // Settle length per code, first pass on the reset default
  task automatic t_sleep();
    int c, e;
    for (int k = 0; k < 4; k++) begin
      c = ORD[k];
      if (k > 0) begin
        unlock();
        xfer(1'b1, `PMWC_IDX_CLK_SEL, {4'h0, c[1:0], c[1:0]});
        // Source output is registered once more after the write
        @(posedge clk_i);
      end
      // First pass runs on the reset default: divided oscillator
      e = (k == 0 || c == 2) ? 0 : c;
      check("clock source", src, e);
      xfer(1'b1, `PMWC_IDX_PWR_CTRL, 8'h04);
      check("sleep regulator", reg_en, 32'h0000_0000);
      i_far.set_line(7, 1'b1);
      i_far.set_line(7, 1'b0);
      wait_wake(1100);
      check("sleep wake", hit, 32'h0000_0001);
      check("sleep mode", mode, 32'h0000_0003);
      // Slow tick phase is unknown, so the first tick may be partial
      check("settle", (n > (SET_LEN[c] - 1) * SLOW) &&
        (n <= SET_LEN[c] * SLOW + 4), 32'h0000_0001);
      check("source kept", src, e);
    end
  endtask : t_sleep

  task automatic t_clockless();
    unlock();
    xfer(1'b1, `PMWC_IDX_WAKE_MASK, 8'h00);
    for (int j = 0; j < 3; j++) begin
      xfer(1'b1, `PMWC_IDX_PWR_CTRL, 8'h02);
      i_far.pulse_src(j);
      wait_wake(10);
      check("clockless wake", hit, 32'h0000_0001);
    end
  endtask : t_clockless

  task automatic t_idle();
    xfer(1'b1, `PMWC_IDX_PWR_CTRL, 8'h01);
    check("idle gates", {cpu_en, per_en, osc_en}, 32'h0000_0003);
    check("watchdog gate", wdt_en, 32'h0000_0000);
    i_far.raise_irq();
    check("idle exit", {cpu_en, mode}, 32'h0000_0005);
    xfer(1'b0, `PMWC_IDX_PWR_CTRL, 8'h00);
    check("idle bit cleared", q, 32'h0000_0000);
    // External clock input, later undone by the reset below
    unlock();
    xfer(1'b1, `PMWC_IDX_CLK_SEL, 8'h03);
    @(posedge clk_i);
    check("external source", src, 32'h0000_0003);
    // Reset also ends idle
    xfer(1'b1, `PMWC_IDX_PWR_CTRL, 8'h01);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset ends idle", cpu_en, 32'h0000_0001);
    check("source after reset", src, 32'h0000_0000);
    xfer(1'b0, `PMWC_IDX_WAKE_MASK, 8'h00);
    check("mask after reset", q, 32'h0000_00FF);
  endtask : t_idle

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_stop_lines();
    t_sleep();
    t_clockless();
    t_idle();
    end_sim();
  end
endmodule : power_mode_wakeup_control_test
